// File: hw/cga_logic_array.sv
`timescale 1ns/1ps
// Summary of operation
// - Enable bit D0 turns pins two to five into the lower gate group.
// - Enable bit D1 turns pins six to nine into the upper group.
// - Lower config D5=0,D4=1 selects XOR; D2 inverts pin three, D0 pin two.
// - Three-input AND mode uses D4,D2,D0 as a code of input inversions.
// - Two-input AND on pins two/three: D0 inverts two, D2 inverts three.
// - Two-input AND on pins two/four: D0 inverts two, D4 inverts four.
// - Two-input AND on pins three/four: D4 and D2 pick the inversions.
// - Upper config uses the same encoding on pins six, seven, eight.
// - Pin-five config D7 cascades lower result upward, D6 inverts pin five.
// - Pin-nine config D7 inverts cascade input, D6 inverts pin nine.
// - Lock bits freeze enable bit and group config; each set once only.
// - Locks clear at reset, and on reset pin when option bit is set.
// - Enabled group drives output pin; port D6 picks push-pull/open-drain.
// - Gate inputs unused by the mode stay ordinary GPIO ports.
module cga_logic_array (
  input logic CLK_SYS,
  input logic RESET,
  input logic [7:0] ADDR,
  input logic [7:0] WR_DATA,
  input logic WR_STROBE,
  input logic RD_STROBE,
  output logic [7:0] RD_DATA,
  input logic RESET_PIN_N,
  input logic [7:0] PIN_IN,
  output logic [7:0] PIN_OUT,
  output logic [7:0] PIN_OE_N,
  input logic [7:0] GPIO_OUT,
  input logic [7:0] GPIO_OE_N
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0] lower_cfg_reg, upper_cfg_reg, five_out_reg, nine_out_reg;
  logic [7:0] port_five_reg, port_nine_reg;
  logic [1:0] enable_reg, lock_reg, result_reg;
  logic option_reg;
  logic [7:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_filt_reg;
  logic rst_s1_reg, rst_s2_reg, rst_s3_reg, rst_filt_reg;
  logic [7:0] pin_out_reg, pin_oe_n_reg, rd_data_reg;
  logic [7:0] pin_filt_next, rd_data_next, drv_out, drv_oe_n;
  logic [1:0] lock_next, enable_next;
  logic rst_filt_next;

  // ---------------------------------------------------------------
  // Gate decoding
  // ---------------------------------------------------------------
  function automatic cga_pkg::cga_mode_type decode_mode(
    input logic [7:0] c);
    if (!c[cga_pkg::CFG_MODE] && c[cga_pkg::CFG_INV_C]) begin
      return cga_pkg::MODE_XOR;
    end else if (!c[cga_pkg::CFG_MODE]) begin
      return cga_pkg::MODE_AND2_AB;
    end else if (c[cga_pkg::CFG_SEL_HI] && c[cga_pkg::CFG_SEL_LO]) begin
      return cga_pkg::MODE_AND3;
    end else if (c[cga_pkg::CFG_SEL_LO]) begin
      return cga_pkg::MODE_AND2_AC;
    end else if (c[cga_pkg::CFG_SEL_HI]) begin
      return cga_pkg::MODE_AND2_BC;
    end
    return cga_pkg::MODE_OFF;
  endfunction

  function automatic logic [2:0] use_mask(input logic [7:0] c);
    unique case (decode_mode(c))
      cga_pkg::MODE_XOR, cga_pkg::MODE_AND2_AB: use_mask = cga_pkg::USE_AB;
      cga_pkg::MODE_AND2_AC: use_mask = cga_pkg::USE_AC;
      cga_pkg::MODE_AND2_BC: use_mask = cga_pkg::USE_BC;
      cga_pkg::MODE_AND3: use_mask = cga_pkg::USE_ALL;
      default: use_mask = cga_pkg::USE_NONE;
    endcase
  endfunction

  function automatic logic [2:0] inv_mask(input logic [7:0] c);
    logic ia, ib, ic;
    logic [2:0] code;
    ia = c[cga_pkg::CFG_INV_A];
    ib = c[cga_pkg::CFG_INV_B];
    ic = c[cga_pkg::CFG_INV_C];
    code = {ic, ib, ia};
    unique case (decode_mode(c))
      cga_pkg::MODE_XOR, cga_pkg::MODE_AND2_AB: inv_mask = {1'b0, ib, ia};
      cga_pkg::MODE_AND2_AC: inv_mask = {ic, 1'b0, ia};
      cga_pkg::MODE_AND2_BC: inv_mask = {ib, ic, 1'b0};
      cga_pkg::MODE_AND3: begin
        if (code == cga_pkg::CODE_INV_C) begin
          inv_mask = cga_pkg::MASK_INV_C;
        end else if (code == cga_pkg::CODE_INV_AB) begin
          inv_mask = cga_pkg::MASK_INV_AB;
        end else begin
          inv_mask = code;
        end
      end
      default: inv_mask = cga_pkg::USE_NONE;
    endcase
  endfunction

  function automatic logic gate_eval(input logic [7:0] c,
                                     input logic [2:0] in);
    logic [2:0] x, u;
    x = in ^ inv_mask(c);
    u = use_mask(c);
    if (decode_mode(c) == cga_pkg::MODE_XOR) begin
      gate_eval = x[0] ^ x[1];
    end else if (u == cga_pkg::USE_NONE) begin
      gate_eval = 1'b0;
    end else begin
      gate_eval = &(x | ~u);
    end
  endfunction

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  wire wr_lower = WR_STROBE && ADDR == cga_pkg::ADDR_LOWER_CFG;
  wire wr_upper = WR_STROBE && ADDR == cga_pkg::ADDR_UPPER_CFG;
  wire wr_enable = WR_STROBE && ADDR == cga_pkg::ADDR_ENABLE;
  wire wr_lock = WR_STROBE && ADDR == cga_pkg::ADDR_LOCK;
  wire wr_lower_ok = wr_lower && !lock_reg[cga_pkg::EN_LOWER];
  wire wr_upper_ok = wr_upper && !lock_reg[cga_pkg::EN_UPPER];
  wire lock_clear = !rst_filt_reg && option_reg;
  wire cascade_on = enable_reg[cga_pkg::EN_LOWER] &&
                    five_out_reg[cga_pkg::OUT_CASCADE];
  wire [7:0] read_mux =
    ADDR == cga_pkg::ADDR_LOWER_CFG ? lower_cfg_reg :
    ADDR == cga_pkg::ADDR_UPPER_CFG ? upper_cfg_reg :
    ADDR == cga_pkg::ADDR_PORT_FIVE ? port_five_reg :
    ADDR == cga_pkg::ADDR_PORT_NINE ? port_nine_reg :
    ADDR == cga_pkg::ADDR_FIVE_OUT ? five_out_reg :
    ADDR == cga_pkg::ADDR_NINE_OUT ? nine_out_reg :
    ADDR == cga_pkg::ADDR_OPTION ? {7'h00, option_reg} :
    ADDR == cga_pkg::ADDR_PIN_LEVEL ? pin_filt_reg :
    ADDR == cga_pkg::ADDR_GATE_STATE ? {6'h00, result_reg} :
    ADDR == cga_pkg::ADDR_ENABLE ? {6'h00, enable_reg} :
    ADDR == cga_pkg::ADDR_LOCK ? {6'h00, lock_reg} : cga_pkg::REG_RESET;

  // Enable bits hold while locked, upper bits are dropped
  assign enable_next = wr_enable ?
    (WR_DATA[1:0] & ~lock_reg) | (enable_reg & lock_reg) :
    enable_reg;
  // A lock bit can only go from clear to set until reset
  assign lock_next = lock_clear ? cga_pkg::PAIR_RESET :
    wr_lock ? lock_reg | WR_DATA[1:0] : lock_reg;
  assign rd_data_next = RD_STROBE ? read_mux : cga_pkg::REG_RESET;

  // Pin filters accept a level once the last two stages agree
  assign pin_filt_next = (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg)) |
                         (pin_filt_reg & (pin_s2_reg ^ pin_s3_reg));
  assign rst_filt_next = (rst_s2_reg == rst_s3_reg) ? rst_s2_reg :
                         rst_filt_reg;

  // ---------------------------------------------------------------
  // Gate groups and pin drive
  // ---------------------------------------------------------------
  logic [7:0] grp_cfg [2];
  logic [7:0] grp_port [2];
  logic [1:0] gate_raw, grp_level;
  logic upper_result, casc_term;

  assign grp_cfg[0] = lower_cfg_reg;
  assign grp_cfg[1] = upper_cfg_reg;
  assign grp_port[0] = port_five_reg;
  assign grp_port[1] = port_nine_reg;
  // Pin five drives the cascade input of the upper gate
  assign grp_level[0] = gate_raw[0] ^ five_out_reg[cga_pkg::OUT_INVERT];
  assign casc_term = grp_level[0] ^ nine_out_reg[cga_pkg::OUT_CASCADE];
  assign upper_result = cascade_on ? gate_raw[1] & casc_term : gate_raw[1];
  assign grp_level[1] = upper_result ^
                        nine_out_reg[cga_pkg::OUT_INVERT];

  genvar g, j;
  generate
    for (g = 0; g < 2; g++) begin : grp
      localparam int BASE = g * cga_pkg::GROUP_SIZE;
      localparam int OUTP = BASE + cga_pkg::GROUP_OUT;
      wire [2:0] used = use_mask(grp_cfg[g]);
      wire push = grp_port[g][cga_pkg::PORT_PUSH_PULL];
      // Live gate from filtered pin levels
      assign gate_raw[g] = gate_eval(grp_cfg[g],
                                     pin_filt_reg[BASE +: 3]);
      for (j = 0; j < cga_pkg::GROUP_OUT; j++) begin : inp
        // Gate inputs float, unused ones stay GPIO
        assign drv_out[BASE + j] = (enable_reg[g] && used[j]) ?
          1'b0 : GPIO_OUT[BASE + j];
        assign drv_oe_n[BASE + j] = (enable_reg[g] && used[j]) ?
          1'b1 : GPIO_OE_N[BASE + j];
      end
      // Output pin: push-pull drives level, open drain only pulls low
      assign drv_out[OUTP] = enable_reg[g] ?
        (push && grp_level[g]) : GPIO_OUT[OUTP];
      assign drv_oe_n[OUTP] = enable_reg[g] ?
        (!push && grp_level[g]) : GPIO_OE_N[OUTP];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Clocked state
  // ---------------------------------------------------------------
  // Software registers
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      lower_cfg_reg <= cga_pkg::REG_RESET;
      upper_cfg_reg <= cga_pkg::REG_RESET;
      five_out_reg <= cga_pkg::REG_RESET;
      nine_out_reg <= cga_pkg::REG_RESET;
      port_five_reg <= cga_pkg::REG_RESET;
      port_nine_reg <= cga_pkg::REG_RESET;
      option_reg <= 1'b0;
    end else if (WR_STROBE) begin
      if (wr_lower_ok) lower_cfg_reg <= WR_DATA;
      if (wr_upper_ok) upper_cfg_reg <= WR_DATA;
      if (ADDR == cga_pkg::ADDR_FIVE_OUT) five_out_reg <= WR_DATA;
      if (ADDR == cga_pkg::ADDR_NINE_OUT) nine_out_reg <= WR_DATA;
      if (ADDR == cga_pkg::ADDR_PORT_FIVE) port_five_reg <= WR_DATA;
      if (ADDR == cga_pkg::ADDR_PORT_NINE) port_nine_reg <= WR_DATA;
      if (ADDR == cga_pkg::ADDR_OPTION) begin
        option_reg <= WR_DATA[cga_pkg::OPT_RST_CLEARS];
      end
    end
  end

  // Enable, lock, results and read port
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      enable_reg <= cga_pkg::PAIR_RESET;
      lock_reg <= cga_pkg::PAIR_RESET;
      result_reg <= cga_pkg::PAIR_RESET;
      rd_data_reg <= cga_pkg::REG_RESET;
    end else begin
      enable_reg <= enable_next;
      lock_reg <= lock_next;
      result_reg <= {upper_result, gate_raw[0]};
      rd_data_reg <= rd_data_next;
    end
  end

  // Input synchronisers and pin drivers
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      pin_s1_reg <= cga_pkg::REG_RESET;
      pin_s2_reg <= cga_pkg::REG_RESET;
      pin_s3_reg <= cga_pkg::REG_RESET;
      pin_filt_reg <= cga_pkg::REG_RESET;
      {rst_s1_reg, rst_s2_reg, rst_s3_reg, rst_filt_reg} <= 4'hF;
      pin_out_reg <= cga_pkg::REG_RESET;
      pin_oe_n_reg <= cga_pkg::PIN_IDLE;
    end else begin
      pin_s1_reg <= PIN_IN;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_filt_reg <= pin_filt_next;
      rst_s1_reg <= RESET_PIN_N;
      rst_s2_reg <= rst_s1_reg;
      rst_s3_reg <= rst_s2_reg;
      rst_filt_reg <= rst_filt_next;
      pin_out_reg <= drv_out;
      pin_oe_n_reg <= drv_oe_n;
    end
  end

  assign RD_DATA = rd_data_reg;
  assign PIN_OUT = pin_out_reg;
  assign PIN_OE_N = pin_oe_n_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  wire lower_en = enable_reg[cga_pkg::EN_LOWER];
  wire [2:0] lp = pin_filt_reg[2:0];
  wire [7:0] lc = lower_cfg_reg;
  cga_pkg::cga_mode_type lower_mode, upper_mode;
  assign lower_mode = decode_mode(lower_cfg_reg);
  assign upper_mode = decode_mode(upper_cfg_reg);

  // Sampled reset keeps the release edge, with reset-valued pins, out
  lower_gpio_a: assert property (!RESET && !lower_en |=>
    PIN_OUT[cga_pkg::PIN_FIVE] == $past(GPIO_OUT[cga_pkg::PIN_FIVE]))
    else $error("pin five not GPIO while lower group off");
  upper_gpio_a: assert property (!RESET && !enable_reg[1] |=>
    PIN_OE_N[cga_pkg::PIN_NINE] == $past(GPIO_OE_N[cga_pkg::PIN_NINE]))
    else $error("pin nine not GPIO while upper group off");
  lower_xor_a: assert property (lc[5:4] == 2'b01 |=>
    result_reg[0] == $past(lp[0] ^ lc[0] ^ lp[1] ^ lc[2]))
    else $error("lower XOR result wrong");
  three_and_a: assert property (lower_mode == cga_pkg::MODE_AND3 &&
    {lc[4], lc[2], lc[0]} == 3'h3 |=> result_reg[0] ==
    $past(lp[0] & lp[1] & !lp[2])) else $error("three-input AND wrong");
  two_and_ab_a: assert property (lc[5:4] == 2'b00 |=>
    result_reg[0] == $past((lp[0] ^ lc[0]) & (lp[1] ^ lc[2])))
    else $error("pin two/three AND wrong");
  two_and_ac_a: assert property (lower_mode == cga_pkg::MODE_AND2_AC |=>
    result_reg[0] == $past((lp[0] ^ lc[0]) & (lp[2] ^ lc[4])))
    else $error("pin two/four AND wrong");
  two_and_bc_a: assert property (lower_mode == cga_pkg::MODE_AND2_BC |=>
    result_reg[0] == $past((lp[1] ^ lc[4]) & (lp[2] ^ lc[2])))
    else $error("pin three/four AND wrong");
  upper_xor_a: assert property (upper_mode == cga_pkg::MODE_XOR &&
    !cascade_on |=> result_reg[1] == $past(pin_filt_reg[4] ^
    upper_cfg_reg[0] ^ pin_filt_reg[5] ^ upper_cfg_reg[2]))
    else $error("upper XOR result wrong");
  five_drive_a: assert property (lower_en && port_five_reg[6] |=>
    !PIN_OE_N[cga_pkg::PIN_FIVE] && PIN_OUT[cga_pkg::PIN_FIVE] ==
    $past(gate_raw[0] ^ five_out_reg[6])) else $error("pin five level");
  cascade_a: assert property (cascade_on && enable_reg[1] &&
    port_nine_reg[6] |=> PIN_OUT[cga_pkg::PIN_NINE] == $past((gate_raw[1] &
    (grp_level[0] ^ nine_out_reg[7])) ^ nine_out_reg[6]))
    else $error("cascade into pin nine wrong");
  cfg_follow_a: assert property (wr_lower_ok |=> ##1
    result_reg[0] == gate_eval($past(WR_DATA, 2), $past(lp)))
    else $error("gate did not follow new configuration");
  lock_hold_a: assert property (lock_reg[0] && !lock_clear |=>
    lock_reg[0] && $stable(lower_cfg_reg) && $stable(enable_reg[0]))
    else $error("locked lower group changed");
  lock_clear_a: assert property (lock_clear |=> lock_reg == 2'h0)
    else $error("reset pin did not clear locks");
  open_drain_a: assert property (lower_en && !port_five_reg[6] |=>
    !PIN_OUT[cga_pkg::PIN_FIVE]) else $error("open drain drove high");
  unused_gpio_a: assert property (lower_en &&
    lower_mode == cga_pkg::MODE_XOR |=> PIN_OE_N[cga_pkg::PIN_FOUR] ==
    $past(GPIO_OE_N[cga_pkg::PIN_FOUR])) else $error("pin four not GPIO");

  cascade_c: cover property (cascade_on && enable_reg[1]);
  both_locked_c: cover property (lock_reg == 2'h3);
  xor_high_c: cover property (lower_mode == cga_pkg::MODE_XOR &&
    result_reg[0]);
  ext_clear_c: cover property (lock_clear && lock_reg != 2'h0);

endmodule

// File: hw/cga_pkg.sv
package cga_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT_FIVE = 8'h05;
  localparam logic [7:0] ADDR_PORT_NINE = 8'h09;
  localparam logic [7:0] ADDR_LOWER_CFG = 8'h28;
  localparam logic [7:0] ADDR_UPPER_CFG = 8'h29;
  localparam logic [7:0] ADDR_OPTION = 8'h2A;
  localparam logic [7:0] ADDR_PIN_LEVEL = 8'h2B;
  localparam logic [7:0] ADDR_FIVE_OUT = 8'h2C;
  localparam logic [7:0] ADDR_NINE_OUT = 8'h2D;
  localparam logic [7:0] ADDR_GATE_STATE = 8'h2E;
  localparam logic [7:0] ADDR_ENABLE = 8'h70;
  localparam logic [7:0] ADDR_LOCK = 8'h71;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] PAIR_RESET = 2'h0;
  localparam logic [7:0] PIN_IDLE = 8'hFF;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int EN_LOWER = 0;
  localparam int EN_UPPER = 1;
  localparam int CFG_INV_A = 0;
  localparam int CFG_SEL_LO = 1;
  localparam int CFG_INV_B = 2;
  localparam int CFG_SEL_HI = 3;
  localparam int CFG_INV_C = 4;
  localparam int CFG_MODE = 5;
  localparam int OUT_CASCADE = 7;
  localparam int OUT_INVERT = 6;
  localparam int PORT_PUSH_PULL = 6;
  localparam int OPT_RST_CLEARS = 0;

  // ---------------------------------------------------------------
  // Pin map, index 0 is pin two
  // ---------------------------------------------------------------
  localparam int GROUP_SIZE = 4;
  localparam int GROUP_OUT = 3;
  localparam int PIN_FOUR = 2;
  localparam int PIN_FIVE = 3;
  localparam int PIN_NINE = 7;

  // ---------------------------------------------------------------
  // Gate modes and input masks
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_XOR = 3'b001,
    MODE_AND2_AB = 3'b010,
    MODE_AND2_AC = 3'b011,
    MODE_AND2_BC = 3'b100,
    MODE_AND3 = 3'b101
  } cga_mode_type;

  localparam logic [2:0] USE_NONE = 3'h0;
  localparam logic [2:0] USE_AB = 3'h3;
  localparam logic [2:0] USE_AC = 3'h5;
  localparam logic [2:0] USE_BC = 3'h6;
  localparam logic [2:0] USE_ALL = 3'h7;
  localparam logic [2:0] CODE_INV_C = 3'h3;
  localparam logic [2:0] CODE_INV_AB = 3'h4;
  localparam logic [2:0] MASK_INV_C = 3'h4;
  localparam logic [2:0] MASK_INV_AB = 3'h3;

endpackage

// File: bench/tb_cga_logic_array.sv
`timescale 1ns/1ps
module tb_cga_logic_array;
  // ---------------------------------------------------------------
  // Bench signals
  // ---------------------------------------------------------------
  logic clk_sys;
  logic reset;
  logic [7:0] addr;
  logic [7:0] wr_data;
  logic wr_strobe;
  logic rd_strobe;
  logic [7:0] rd_data;
  logic reset_pin_n;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe_n;
  logic [7:0] gpio_out;
  logic [7:0] gpio_oe_n;
  logic [7:0] rd_val;
  logic [3:0] g;
  logic [7:0] exp_out;
  logic [7:0] cfgs [29] = '{8'h10, 8'h11, 8'h14, 8'h15, 8'h1A, 8'h1F,
    8'h00, 8'h01, 8'h04, 8'h05, 8'h2A, 8'h2B, 8'h2E, 8'h2F, 8'h3A,
    8'h3B, 8'h3E, 8'h3F, 8'h22, 8'h23, 8'h32, 8'h33, 8'h26, 8'h28,
    8'h38, 8'h2C, 8'h3C, 8'h29, 8'h20};
  int n_fail;
  int cmp_count;

  `define CHK(got, exp) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

  // ---------------------------------------------------------------
  // Design under test
  // ---------------------------------------------------------------
  cga_logic_array DUT (
    .CLK_SYS(clk_sys),
    .RESET(reset),
    .ADDR(addr),
    .WR_DATA(wr_data),
    .WR_STROBE(wr_strobe),
    .RD_STROBE(rd_strobe),
    .RD_DATA(rd_data),
    .RESET_PIN_N(reset_pin_n),
    .PIN_IN(pin_in),
    .PIN_OUT(pin_out),
    .PIN_OE_N(pin_oe_n),
    .GPIO_OUT(gpio_out),
    .GPIO_OE_N(gpio_oe_n)
  );

  // Clock at 40 ns period
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // Bus tasks and expected gate model
  // ---------------------------------------------------------------
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clk_sys);
    wr_strobe <= 1'b0;
  endtask

  // Read data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk_sys);
    rd_strobe <= 1'b0;
    #1;
    rd_val = rd_data;
    // Return on an edge so that following drives stay edge-aligned
    @(posedge clk_sys);
  endtask

  // Let filters and registered outputs settle
  task automatic settle();
    repeat (6) @(posedge clk_sys);
    #1;
  endtask

  // Returns {inputs used, result}; a is pin two side, c pin four side
  function automatic logic [3:0] gate_exp(input logic [7:0] c,
                                          input logic [2:0] p);
    logic [2:0] inv;
    inv = {c[4], c[2], c[0]};
    if (!c[5] && c[4])
      return {3'h3, (p[0] ^ c[0]) ^ (p[1] ^ c[2])};
    if (!c[5])
      return {3'h3, (p[0] ^ c[0]) & (p[1] ^ c[2])};
    if (c[3] && c[1]) begin
      // Codes three and four name pin four alone and pins two/three
      if (inv == 3'h3)
        inv = 3'h4;
      else if (inv == 3'h4)
        inv = 3'h3;
      return {3'h7, &(p ^ inv)};
    end
    if (c[1])
      return {3'h5, (p[0] ^ c[0]) & (p[2] ^ c[4])};
    if (c[3])
      return {3'h6, (p[1] ^ c[4]) & (p[2] ^ c[2])};
    return 4'h0;
  endfunction

  // Closing report
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    print_verdict();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    reset = 1'b1;
    addr = 8'h00;
    wr_data = 8'h00;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    reset_pin_n = 1'b1;
    pin_in = 8'h00;
    gpio_out = 8'h5A;
    gpio_oe_n = 8'h0F;
    n_fail = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    settle();
    // Disabled groups pass GPIO straight through
    `CHK(pin_out, 8'h5A)
    `CHK(pin_oe_n, 8'h0F)
    foreach (cfgs[i]) begin
      if (i < 9) begin
        rd(8'h28 + 8'(i % 6));
        `CHK(rd_val, 8'h00)
      end
    end
    wr(8'h40, 8'hFF);
    rd(8'h40);
    `CHK(rd_val, 8'h00)
    wr(8'h05, 8'h40);
    wr(8'h09, 8'h40);
    wr(8'h70, 8'hFF);
    rd(8'h70);
    `CHK(rd_val, 8'h03)
    gpio_oe_n <= 8'h00;
    // Nonzero read data stands one cycle only
    #1;
    `CHK(rd_data, 8'h00)
    // Every mode and inversion across all input combinations
    foreach (cfgs[i]) begin
      wr(8'h28, cfgs[i]);
      wr(8'h29, cfgs[i]);
      for (int p = 0; p < 8; p++) begin
        pin_in <= {1'b0, 3'(p), 1'b0, 3'(p)};
        settle();
        g = gate_exp(cfgs[i], 3'(p));
        exp_out = {g[0], gpio_out[6:4] & ~g[3:1], g[0],
          gpio_out[2:0] & ~g[3:1]};
        `CHK(pin_out, exp_out)
        `CHK(pin_oe_n, {1'b0, g[3:1], 1'b0, g[3:1]})
        rd(8'h2E);
        `CHK(rd_val, {6'h00, g[0], g[0]})
      end
    end
    // Output inversion and open-drain pin five
    pin_in <= 8'h77;
    wr(8'h28, 8'h00);
    wr(8'h29, 8'h00);
    wr(8'h2C, 8'h40);
    wr(8'h2D, 8'h40);
    settle();
    `CHK({pin_out[7], pin_out[3]}, 2'b00)
    wr(8'h05, 8'h00);
    settle();
    `CHK({pin_out[3], pin_oe_n[3]}, 2'b00)
    wr(8'h2C, 8'h00);
    settle();
    `CHK({pin_out[3], pin_oe_n[3]}, 2'b01)
    wr(8'h05, 8'h40);
    // Cascade of the lower result into the upper gate
    wr(8'h2C, 8'h80);
    for (int k = 0; k < 4; k++) begin
      pin_in <= {6'b001100, {2{k[0]}}};
      wr(8'h2D, {k[1], 7'h00});
      settle();
      `CHK(pin_out[7], k[0] ^ k[1])
      rd(8'h2E);
      `CHK(rd_val, {6'h00, k[0] ^ k[1], k[0]})
    end
    // Lock freezes lower config and enable bit
    wr(8'h2C, 8'h00);
    wr(8'h28, 8'h10);
    wr(8'h71, 8'h01);
    wr(8'h28, 8'h00);
    rd(8'h28);
    `CHK(rd_val, 8'h10)
    wr(8'h70, 8'h00);
    rd(8'h70);
    `CHK(rd_val, 8'h01)
    wr(8'h71, 8'h00);
    rd(8'h71);
    `CHK(rd_val, 8'h01)
    wr(8'h29, 8'h05);
    rd(8'h29);
    `CHK(rd_val, 8'h05)
    // Reset pin clears locks only with the option set
    for (int k = 0; k < 2; k++) begin
      wr(8'h2A, 8'(k));
      reset_pin_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      reset_pin_n <= 1'b1;
      settle();
      rd(8'h71);
      `CHK(rd_val, 8'(1 - k))
    end
    wr(8'h28, 8'h00);
    rd(8'h28);
    `CHK(rd_val, 8'h00)
    // Power-up reset in mid-run clears both locks
    wr(8'h71, 8'h03);
    reset <= 1'b1;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    rd(8'h71);
    `CHK(rd_val, 8'h00)
    print_verdict();
  end
endmodule
